// file: core/asp_core.sv
// Audio serial port core: clock generation, framing, shifters, queues
// Function
// - Separate full-duplex tx and rx paths, each with clock, sync, data.
// - Interrupt mode buffers in queues; DMA mode in slot holding registers.
// - Shift clocks are never gated; they run whenever the port is enabled.
// - Words are 8 or 16 bits only.
// - Receive and transmit queues hold sixteen words each.
// - Transmit data leaves MSB first, changing on rising shift clock edges.
// - Data output floats at falling edge of last bit unless next word follows.
// - Tx clock pin two-way; clocks tx alone async, both paths sync.
// - Tx sync pin two-way; frames tx alone async, both paths sync.
// - Receive samples on falling edges, MSB first; sync mode uses tx clock.
// - In sync mode rx clock and rx sync pins become general pins.
// - Internal clock for both paths comes from one shared prescaler set; rx gets internal sync only in sync mode.
// - Each rising frame sync starts a new frame and a new slot.
// - Only bits after the sync are valid; words go to queue or holding zero.
// - Receive interrupt when queue occupancy exceeds the warning limit.
// - Transmit interrupt when queued words are at or below the warning limit.
// - Rx DMA: word goes to holding zero; request while it is full.
// - Tx DMA: word comes from holding zero; request while it is empty.
// - Bit clock is input clock divided by eight-bit divider plus one.
module asp_core
   import asp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                 CORE_CLK_I,
   input  wire logic                 RESET_I,
   // Configuration
   input  wire asp_cfg_s             CFG_I,
   input  wire logic [1:0]           GP_OUT_I,
   input  wire logic [1:0]           GP_OE_I,
   output      logic [1:0]           GP_IN_O,
   // Processor write side
   input  wire logic                 TX_WR_I,
   input  wire logic [WORD_W-1:0]    TX_WDATA_I,
   output      logic                 TX_READY_O,
   // Processor read side
   input  wire logic                 RX_RD_I,
   output      logic                 RX_AVAIL_O,
   output      logic [WORD_W-1:0]    RX_RDATA_O,
   output      logic                 RX_VALID_O,
   // Interrupt and DMA requests
   output      logic                 RX_IRQ_O,
   output      logic                 TX_IRQ_O,
   output      logic                 RX_DMA_REQ_O,
   output      logic                 TX_DMA_REQ_O,
   // Transmit pins
   output      logic                 TX_DATA_O,
   output      logic                 TX_DATA_OE_N_O,
   input  wire logic                 TX_CLK_I,
   output      logic                 TX_CLK_O,
   output      logic                 TX_CLK_OE_N_O,
   input  wire logic                 TX_FS_I,
   output      logic                 TX_FS_O,
   output      logic                 TX_FS_OE_N_O,
   // Receive pins
   input  wire logic                 RX_DATA_I,
   input  wire logic                 RX_CLK_I,
   output      logic                 RX_CLK_O,
   output      logic                 RX_CLK_OE_N_O,
   input  wire logic                 RX_FS_I,
   output      logic                 RX_FS_O,
   output      logic                 RX_FS_OE_N_O
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int SYN_TCLK = 4;
   localparam int SYN_TFS  = 3;
   localparam int SYN_RCLK = 2;
   localparam int SYN_RFS  = 1;
   localparam int SYN_RDAT = 0;

   if (DEPTH != FIFO_DEPTH) begin : g_chk
      $error("asp_core: queues must hold sixteen words");
   end

   asp_state_s              st_reg;
   asp_state_s              st_next;
   logic                    en;
   logic                    tclk;
   logic                    tfs;
   logic                    rclk;
   logic                    rfs;
   logic                    t_rise;
   logic                    t_fall;
   logic                    r_fall;
   logic [LEN_W-1:0]        word_len;
   logic [DIV_W-1:0]        half;
   logic [WORD_W-1:0]       rx_word;
   logic [WORD_W-1:0]       tx_word;
   logic                    tx_word_ok;
   logic                    txq_push;
   logic                    txq_pop;
   logic                    txq_full;
   logic                    txq_empty;
   logic [WORD_W-1:0]       txq_rdata;
   logic [CNT_W-1:0]        txq_cnt;
   logic                    rxq_push;
   logic                    rxq_pop;
   logic                    rxq_full;
   logic                    rxq_empty;
   logic [WORD_W-1:0]       rxq_rdata;
   logic [CNT_W-1:0]        rxq_cnt;

   // ----------------------------------------------------------------
   // Clock and sync selection
   // ----------------------------------------------------------------
   assign en       = CFG_I.enable;
   assign word_len = CFG_I.word16 ? WORD16_LEN : WORD8_LEN;
   assign half     = DIV_W'((9'(CFG_I.bit_clock_divider) + 9'h001) >> 1);

   // Both paths take internal clock from the one shared divider; rx takes internal sync only in sync mode
   assign tclk = CFG_I.clk_int ? st_reg.gen_clk : st_reg.sync2[SYN_TCLK];
   assign tfs  = CFG_I.fs_int ? st_reg.gen_fs : st_reg.sync2[SYN_TFS];
   // Synchronous mode runs the receiver from the tx clock and sync
   assign rclk = CFG_I.sync_mode ? tclk :
                 (CFG_I.clk_int ? st_reg.gen_clk : st_reg.sync2[SYN_RCLK]);
   assign rfs  = CFG_I.sync_mode ? tfs : st_reg.sync2[SYN_RFS];

   // Edges of the selected clocks, seen at the core clock
   assign t_rise = en && tclk && !st_reg.tclk_prev;
   assign t_fall = en && !tclk && st_reg.tclk_prev;
   assign r_fall = en && !rclk && st_reg.rclk_prev;

   // Word offered by the transmit source: holding zero or queue
   assign tx_word    = CFG_I.tx_slot0_dma_select ? st_reg.tx_dma_holding_zero : txq_rdata;
   assign tx_word_ok = CFG_I.tx_slot0_dma_select ? st_reg.tx_hold_full : !txq_empty;

   // Completed receive word, upper byte cleared for 8-bit words
   assign rx_word = CFG_I.word16 ? {st_reg.rx_shift_register[WORD_W-2:0], st_reg.sync2[SYN_RDAT]} :
                    {HIGH_BYTE_0, st_reg.rx_shift_register[MSB8_POS-1:0], st_reg.sync2[SYN_RDAT]};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next  = st_reg;
      txq_push = 1'b0;
      txq_pop  = 1'b0;
      rxq_push = 1'b0;
      rxq_pop  = 1'b0;

      // Pin inputs pass two flops before anything reads them
      st_next.sync1 = {TX_CLK_I, TX_FS_I, RX_CLK_I, RX_FS_I, RX_DATA_I};
      st_next.sync2 = st_reg.sync1;
      st_next.tclk_prev = tclk;
      st_next.rclk_prev = rclk;

      // Divider runs freely while enabled, never gated
      if (!en) begin
         st_next.div_cnt = '0;
         st_next.gen_clk = 1'b0;
         st_next.bit_cnt = '0;
         st_next.gen_fs  = 1'b0;
      end else begin
         st_next.div_cnt = (st_reg.div_cnt == CFG_I.bit_clock_divider) ? '0 : st_reg.div_cnt + 1'b1;
         st_next.gen_clk = (st_next.div_cnt < half);
         // Frame sync marks bit zero of each frame of frame_len_m1+1 bits
         if (st_next.div_cnt == '0) begin
            st_next.bit_cnt = (st_reg.bit_cnt == CFG_I.frame_len_m1) ? '0 : st_reg.bit_cnt + 1'b1;
            st_next.gen_fs  = (st_next.bit_cnt == '0);
         end
      end

      // Transmit falling edge: catch a new sync, end a finished word
      if (t_fall) begin
         st_next.tfs_prev = tfs;
         if (tfs && !st_reg.tfs_prev) begin
            st_next.tx_start = 1'b1;
         end
         if (st_reg.tx_state == ASP_TX_SHIFT && st_reg.tx_left == LAST_BIT) begin
            st_next.tx_left  = '0;
            st_next.tx_state = ASP_TX_IDLE;
            // A following word keeps the pin driven to avoid a glitch
            if (!(tfs && !st_reg.tfs_prev && tx_word_ok)) begin
               st_next.tx_oe_n = 1'b1;
            end
         end
      end

      // Transmit rising edge: load a new word or shift the next bit
      if (t_rise) begin
         if (st_reg.tx_start) begin
            st_next.tx_start = 1'b0;
            if (tx_word_ok) begin
               st_next.tx_shift_register = tx_word;
               st_next.tx_left  = word_len;
               st_next.tx_state = ASP_TX_SHIFT;
               st_next.tx_oe_n  = 1'b0;
               st_next.tx_dout  = CFG_I.word16 ? tx_word[MSB16_POS] : tx_word[MSB8_POS];
               if (CFG_I.tx_slot0_dma_select) begin
                  st_next.tx_hold_full = 1'b0;
               end else begin
                  txq_pop = 1'b1;
               end
            end else begin
               // Nothing to send: the slot stays undriven
               st_next.tx_oe_n = 1'b1;
            end
         end else if (st_reg.tx_state == ASP_TX_SHIFT) begin
            st_next.tx_shift_register = {st_reg.tx_shift_register[WORD_W-2:0], 1'b0};
            st_next.tx_left = st_reg.tx_left - 1'b1;
            st_next.tx_dout = CFG_I.word16 ? st_reg.tx_shift_register[MSB16_POS-1] :
                              st_reg.tx_shift_register[MSB8_POS-1];
         end
      end

      // Processor read: clear first so a word landing now still wins
      st_next.rd_valid = 1'b0;
      if (RX_RD_I) begin
         if (CFG_I.rx_slot0_dma_select) begin
            if (st_reg.rx_hold_full) begin
               st_next.rd_data      = st_reg.rx_dma_holding_zero;
               st_next.rd_valid     = 1'b1;
               st_next.rx_hold_full = 1'b0;
            end
         end else if (!rxq_empty) begin
            st_next.rd_data  = rxq_rdata;
            st_next.rd_valid = 1'b1;
            rxq_pop          = 1'b1;
         end
      end

      // Receive falling edge: sync arms, later samples are data
      if (r_fall) begin
         st_next.rfs_prev = rfs;
         if (rfs && !st_reg.rfs_prev) begin
            st_next.rx_left = word_len;
            st_next.rx_shift_register = '0;
         end else if (st_reg.rx_left != '0) begin
            st_next.rx_shift_register = {st_reg.rx_shift_register[WORD_W-2:0], st_reg.sync2[SYN_RDAT]};
            st_next.rx_left = st_reg.rx_left - 1'b1;
            if (st_reg.rx_left == LAST_BIT) begin
               if (CFG_I.rx_slot0_dma_select) begin
                  st_next.rx_dma_holding_zero = rx_word;
                  st_next.rx_hold_full        = 1'b1;
               end else begin
                  rxq_push = 1'b1;
               end
            end
         end
      end

      // Processor write: holding zero in DMA mode, queue otherwise
      if (TX_WR_I) begin
         if (CFG_I.tx_slot0_dma_select) begin
            if (!st_reg.tx_hold_full) begin
               st_next.tx_dma_holding_zero = TX_WDATA_I;
               st_next.tx_hold_full        = 1'b1;
            end
         end else begin
            txq_push = 1'b1;
         end
      end

      // Disabled port keeps its line state idle
      if (!en) begin
         st_next.tx_state = ASP_TX_IDLE;
         st_next.tx_oe_n  = 1'b1;
         st_next.tx_start = 1'b0;
         st_next.tx_left  = '0;
         st_next.rx_left  = '0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         st_reg         <= '0;
         st_reg.tx_oe_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Queues
   // ----------------------------------------------------------------
   // Full queues drop: the rx word is lost, the tx write is refused
   asp_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_txq (
      .clk_i   (CORE_CLK_I),
      .rst_i   (RESET_I),
      .push_i  (txq_push),
      .wdata_i (TX_WDATA_I),
      .full_o  (txq_full),
      .pop_i   (txq_pop),
      .rdata_o (txq_rdata),
      .empty_o (txq_empty),
      .count_o (txq_cnt)
   );

   asp_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_rxq (
      .clk_i   (CORE_CLK_I),
      .rst_i   (RESET_I),
      .push_i  (rxq_push),
      .wdata_i (rx_word),
      .full_o  (rxq_full),
      .pop_i   (rxq_pop),
      .rdata_o (rxq_rdata),
      .empty_o (rxq_empty),
      .count_o (rxq_cnt)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Processor handshake and requests
   assign TX_READY_O   = CFG_I.tx_slot0_dma_select ? !st_reg.tx_hold_full : !txq_full;
   assign RX_AVAIL_O   = CFG_I.rx_slot0_dma_select ? st_reg.rx_hold_full : !rxq_empty;
   assign RX_RDATA_O   = st_reg.rd_data;
   assign RX_VALID_O   = st_reg.rd_valid;
   assign RX_IRQ_O     = en && !CFG_I.rx_slot0_dma_select && (rxq_cnt > CFG_I.rx_warn);
   assign TX_IRQ_O     = en && !CFG_I.tx_slot0_dma_select && (txq_cnt <= CFG_I.tx_warn);
   assign RX_DMA_REQ_O = CFG_I.rx_slot0_dma_select && st_reg.rx_hold_full;
   assign TX_DMA_REQ_O = en && CFG_I.tx_slot0_dma_select && !st_reg.tx_hold_full;

   // Transmit pins; enables are low while driving
   assign TX_DATA_O      = st_reg.tx_dout;
   assign TX_DATA_OE_N_O = st_reg.tx_oe_n;
   assign TX_CLK_O       = st_reg.gen_clk;
   assign TX_CLK_OE_N_O  = !(en && CFG_I.clk_int);
   assign TX_FS_O        = st_reg.gen_fs;
   assign TX_FS_OE_N_O   = !(en && CFG_I.fs_int);

   // Receive pins turn into general pins in synchronous mode
   assign RX_CLK_O      = CFG_I.sync_mode ? GP_OUT_I[0] : st_reg.gen_clk;
   assign RX_CLK_OE_N_O = CFG_I.sync_mode ? !GP_OE_I[0] : !(en && CFG_I.clk_int);
   assign RX_FS_O       = GP_OUT_I[1];
   assign RX_FS_OE_N_O  = !(CFG_I.sync_mode && GP_OE_I[1]);
   assign GP_IN_O       = {st_reg.sync2[SYN_RFS], st_reg.sync2[SYN_RCLK]};

endmodule

// file: inc/asp_pkg.sv
// Shared constants and types of the audio serial port
package asp_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH = 16;             // Words per queue
   localparam int WORD_W     = 16;             // Widest data word
   localparam int DIV_W      = 8;              // Bit clock divider width
   localparam int FRAME_W    = 7;              // Frame length field width
   localparam int LEN_W      = 5;              // Bit counter width
   localparam int CNT_W      = $clog2(FIFO_DEPTH) + 1;

   // ----------------------------------------------------------------
   // Word lengths and positions
   // ----------------------------------------------------------------
   localparam logic [LEN_W-1:0] WORD8_LEN   = 5'h08;
   localparam logic [LEN_W-1:0] WORD16_LEN  = 5'h10;
   localparam logic [LEN_W-1:0] LAST_BIT    = 5'h01;
   localparam int               MSB16_POS   = 15;
   localparam int               MSB8_POS    = 7;
   localparam logic [7:0]       HIGH_BYTE_0 = 8'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic {ASP_TX_IDLE, ASP_TX_SHIFT} asp_tx_e;

   // Static configuration from the control side
   typedef struct packed {
      logic                   enable;       // Port on, clocks run
      logic                   sync_mode;    // Receiver uses tx clock and sync
      logic                   clk_int;      // Bit clock made here
      logic                   fs_int;       // Frame sync made here
      logic                   word16;       // 16-bit words, else 8
      logic [DIV_W-1:0]       bit_clock_divider;
      logic [FRAME_W-1:0]     frame_len_m1; // Bits per frame minus one
      logic                   rx_slot0_dma_select;
      logic                   tx_slot0_dma_select;
      logic [CNT_W-1:0]       rx_warn;
      logic [CNT_W-1:0]       tx_warn;
   } asp_cfg_s;

   // Whole state of the port core
   typedef struct packed {
      logic [DIV_W-1:0]   div_cnt;
      logic               gen_clk;
      logic [FRAME_W-1:0] bit_cnt;
      logic               gen_fs;
      logic [4:0]         sync1;     // First stage: tclk, tfs, rclk, rfs, rdata
      logic [4:0]         sync2;
      logic               tclk_prev;
      logic               rclk_prev;
      logic               tfs_prev;
      logic               rfs_prev;
      logic               tx_start;
      asp_tx_e            tx_state;
      logic [WORD_W-1:0]  tx_shift_register;
      logic [LEN_W-1:0]   tx_left;
      logic               tx_oe_n;
      logic               tx_dout;
      logic [WORD_W-1:0]  rx_shift_register;
      logic [LEN_W-1:0]   rx_left;
      logic [WORD_W-1:0]  rx_dma_holding_zero;
      logic               rx_hold_full;
      logic [WORD_W-1:0]  tx_dma_holding_zero;
      logic               tx_hold_full;
      logic [WORD_W-1:0]  rd_data;
      logic               rd_valid;
   } asp_state_s;

endpackage

// file: core/asp_fifo.sv
// Word queue with occupancy count for the audio serial port
module asp_fifo
   import asp_pkg::*;
#(
   parameter int W     = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // Write side
   input  wire logic                       push_i,
   input  wire logic [W-1:0]               wdata_i,
   output      logic                       full_o,
   // Read side
   input  wire logic                       pop_i,
   output      logic [W-1:0]               rdata_o,
   output      logic                       empty_o,
   output      logic [$clog2(DEPTH):0]     count_o
);

   localparam int AW = $clog2(DEPTH);

   // Pointers wrap naturally, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("asp_fifo: DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } asp_fifo_s;

   asp_fifo_s      st_reg;
   asp_fifo_s      st_next;
   logic [W-1:0]   mem [DEPTH];
   logic           do_push;
   logic           do_pop;

   // Refuse pushes when full and pops when empty
   assign do_push = push_i && (st_reg.cnt != (AW+1)'(DEPTH));
   assign do_pop  = pop_i && (st_reg.cnt != '0);

   always_comb begin
      st_next = st_reg;
      if (do_push) begin
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (do_pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
      st_next.cnt = st_reg.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage has no reset, only valid words are ever read
   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem[st_reg.wr] <= wdata_i;
      end
   end

   assign rdata_o = mem[st_reg.rd];
   assign full_o  = (st_reg.cnt == (AW+1)'(DEPTH));
   assign empty_o = (st_reg.cnt == '0);
   assign count_o = st_reg.cnt;

endmodule

// file: sim/asp_core_props.sv
// Pin-level checks on the audio serial port core
module asp_core_props
   import asp_pkg::*;
(
   input wire logic             CORE_CLK_I,
   input wire logic             RESET_I,
   input wire asp_cfg_s         CFG_I,
   input wire logic [1:0]       GP_OUT_I,
   input wire logic [1:0]       GP_OE_I,
   input wire logic             TX_WR_I,
   input wire logic             RX_RD_I,
   input wire logic             RX_AVAIL_O,
   input wire logic             RX_VALID_O,
   input wire logic             RX_IRQ_O,
   input wire logic             TX_IRQ_O,
   input wire logic             RX_DMA_REQ_O,
   input wire logic             TX_DMA_REQ_O,
   input wire logic             TX_DATA_O,
   input wire logic             TX_DATA_OE_N_O,
   input wire logic             TX_CLK_O,
   input wire logic             TX_CLK_OE_N_O,
   input wire logic             TX_FS_OE_N_O,
   input wire logic             RX_FS_O,
   input wire logic             RX_FS_OE_N_O
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DIV_W-1:0] hold_cnt;

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RESET_I);

   // Cycles the bit clock has held its level; a stuck clock grows it
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || !CFG_I.enable || TX_CLK_O != $past(TX_CLK_O)) hold_cnt <= '0;
      else hold_cnt <= hold_cnt + 1'b1;
   end

   a_read_answer: assert property (RX_RD_I && RX_AVAIL_O |=> RX_VALID_O)
      else $error("read without valid answer");
   a_read_refused: assert property (!(RX_RD_I && RX_AVAIL_O) |=> !RX_VALID_O)
      else $error("valid without accepted read");
   a_rx_irq_mode: assert property (RX_IRQ_O |-> CFG_I.enable && !CFG_I.rx_slot0_dma_select)
      else $error("rx irq outside queue mode");
   a_tx_irq_mode: assert property (TX_IRQ_O |-> CFG_I.enable && !CFG_I.tx_slot0_dma_select)
      else $error("tx irq outside queue mode");
   a_rx_req_mode: assert property (RX_DMA_REQ_O |-> CFG_I.rx_slot0_dma_select)
      else $error("rx dma request in queue mode");
   a_tx_req_fill: assert property (TX_DMA_REQ_O && TX_WR_I |=> !TX_DMA_REQ_O)
      else $error("tx dma request after fill");
   a_oe_release: assert property ($rose(TX_DATA_OE_N_O) && CFG_I.clk_int |-> !TX_CLK_O)
      else $error("data released outside clock low");
   a_data_edge: assert property ($fell(TX_CLK_O) && !TX_DATA_OE_N_O && $past(!TX_DATA_OE_N_O)
      |-> $stable(TX_DATA_O))
      else $error("data moved on falling edge");
   a_clk_drive: assert property (CFG_I.enable && CFG_I.clk_int && $stable(CFG_I) |-> !TX_CLK_OE_N_O)
      else $error("internal clock not driven");
   a_fs_drive: assert property (CFG_I.enable && CFG_I.fs_int && $stable(CFG_I) |-> !TX_FS_OE_N_O)
      else $error("internal sync not driven");
   a_rx_fs_gp: assert property (CFG_I.sync_mode |-> RX_FS_O == GP_OUT_I[1]
      && RX_FS_OE_N_O == !GP_OE_I[1])
      else $error("rx sync pin not general purpose");
   a_clk_runs: assert property (CFG_I.enable && CFG_I.clk_int |-> hold_cnt <= CFG_I.bit_clock_divider)
      else $error("bit clock stalled");
endmodule

// file: sim/asp_codec_model.sv
// Codec model: one word per frame out, collects transmitted words
module asp_codec_model (
   input  wire logic        bclk_i,
   input  wire logic        fs_i,
   input  wire logic        dout_i,
   input  wire logic        dout_oe_n_i,
   input  wire logic        word16_i,
   output logic             din_o = 1'b0,
   output logic [15:0]      sent_o = 16'h0000,
   output logic [15:0]      got_o = 16'h0000,
   output logic             got_tgl_o = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        fs_seen = 1'b0;
   logic [7:0]  frame_k = 8'h00;
   logic [4:0]  tx_n = 5'h00;
   logic [4:0]  rx_n = 5'h00;
   logic [15:0] sh = 16'h0000;
   logic [15:0] cap = 16'h0000;

   // Sample sync and port data on falling edges, MSB first
   always @(negedge bclk_i) begin
      fs_seen <= fs_i;
      if (!dout_oe_n_i) begin
         cap = {cap[14:0], dout_i};
         rx_n = rx_n + 5'h01;
         if (rx_n == (word16_i ? 5'h10 : 5'h08)) begin
            got_o <= cap;
            got_tgl_o <= ~got_tgl_o;
            rx_n = 5'h00;
         end
      end
   end

   // Word starts on the rising edge after sync; line wiggles when released
   always @(posedge bclk_i) begin
      if (fs_seen) begin
         sh = {frame_k, ~frame_k};
         sent_o <= sh;
         frame_k = frame_k + 8'h01;
         tx_n = 5'h10;
      end
      if (tx_n != 5'h00) begin
         din_o <= sh[15];
         sh = sh << 1;
         tx_n = tx_n - 5'h01;
      end else din_o <= ~din_o;
   end
endmodule

// file: sim/tb.sv
// Self-checking bench for the audio serial port core
module tb import asp_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rx_din, seen_tgl;
   logic [WORD_W-1:0] wdata = '0, rdata, sent, got;
   logic [1:0] gp_out = 2'b10, gp_oe = 2'b11, gp_in;
   logic tx_ready, rx_avail, rx_valid, rx_irq, tx_irq, rx_req, tx_req, tx_d, tx_oe_n, tx_clk, tx_fs, got_tgl;
   int mismatches = 0, comparisons = 0, cyc = 0;
   asp_cfg_s cfg = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h07, 7'h13, 1'b0, 1'b0, 5'h00, 5'h01};

   // Clock and sync pins loop back for the outside-timing run; rx pins echo the general outputs
   asp_core #(.DEPTH(16)) dut_u (.CORE_CLK_I(clk), .RESET_I(rst), .CFG_I(cfg), .GP_OUT_I(gp_out),
      .GP_OE_I(gp_oe), .GP_IN_O(gp_in), .TX_WR_I(wr_en), .TX_WDATA_I(wdata), .TX_READY_O(tx_ready),
      .RX_RD_I(rd_en), .RX_AVAIL_O(rx_avail), .RX_RDATA_O(rdata), .RX_VALID_O(rx_valid),
      .RX_IRQ_O(rx_irq), .TX_IRQ_O(tx_irq), .RX_DMA_REQ_O(rx_req), .TX_DMA_REQ_O(tx_req),
      .TX_DATA_O(tx_d), .TX_DATA_OE_N_O(tx_oe_n), .TX_CLK_I(tx_clk), .TX_CLK_O(tx_clk),
      .TX_CLK_OE_N_O(), .TX_FS_I(tx_fs), .TX_FS_O(tx_fs), .TX_FS_OE_N_O(), .RX_DATA_I(rx_din),
      .RX_CLK_I(gp_out[0]), .RX_CLK_O(), .RX_CLK_OE_N_O(), .RX_FS_I(gp_out[1]), .RX_FS_O(), .RX_FS_OE_N_O());
   asp_codec_model codec_u (.bclk_i(tx_clk), .fs_i(tx_fs), .dout_i(tx_d), .dout_oe_n_i(tx_oe_n),
      .word16_i(cfg.word16), .din_o(rx_din), .sent_o(sent), .got_o(got), .got_tgl_o(got_tgl));

   // 100 MHz clock and a cycle ceiling against hangs
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic do_reset();
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      seen_tgl = got_tgl;
   endtask
   task automatic wr(input logic [15:0] d);
      @(posedge clk);
      #1 wr_en = 1'b1;
      wdata = d;
      @(posedge clk);
      #1 wr_en = 1'b0;
   endtask
   task automatic rd(input logic [15:0] e);
      @(posedge clk);
      #1 rd_en = 1'b1;
      @(posedge clk);
      #1 rd_en = 1'b0;
      chk(rx_valid, 1'b1);
      chk(rdata, e);
   endtask
   // Bounded wait for the next word collected by the codec
   task automatic wait_word();
      int n;
      n = 0;
      while (got_tgl === seen_tgl && n < 500) begin
         @(posedge clk);
         n++;
      end
      seen_tgl = got_tgl;
      chk(n < 500, 1'b1);
   endtask
   task automatic finish_test();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Queue mode, 16-bit words, then slot-zero holding mode, 8-bit words, outside timing
   initial begin
      do_reset();
      chk(tx_oe_n, 1'b1);
      for (int i = 0; i < 16; i++) wr(16'(16'hb400 ^ (i * 16'h0111)));
      chk(tx_ready, 1'b0);
      wr(16'hffff);
      cfg.enable = 1'b1;
      gp_out = 2'b01;
      @(posedge clk);
      #1 chk(tx_irq, 1'b0);
      for (int i = 0; i < 16; i++) begin
         wait_word();
         chk(got, 16'(16'hb400 ^ (i * 16'h0111)));
      end
      repeat (400) @(posedge clk);
      chk(got_tgl, seen_tgl);
      chk(tx_oe_n, 1'b1);
      chk(tx_irq, 1'b1);
      chk(rx_irq, 1'b1);
      chk(gp_in, 2'b01);
      for (int i = 0; i < 16; i++) rd({i[7:0], ~i[7:0]});
      cfg = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h07, 7'h13, 1'b1, 1'b1, 5'h00, 5'h01};
      do_reset();
      chk(tx_req, 1'b1);
      wr(16'h12c3);
      chk(tx_req, 1'b0);
      for (int n = 0; n < 500 && rx_req !== 1'b1; n++) @(posedge clk);
      chk(rx_req, 1'b1);
      rd({8'h00, sent[15:8]});
      chk(rx_req, 1'b0);
      wait_word();
      chk(got[7:0], 8'hc3);
      finish_test();
   end
endmodule

bind asp_core asp_core_props chk_u (.CORE_CLK_I, .RESET_I, .CFG_I, .GP_OUT_I, .GP_OE_I, .TX_WR_I,
   .RX_RD_I, .RX_AVAIL_O, .RX_VALID_O, .RX_IRQ_O, .TX_IRQ_O, .RX_DMA_REQ_O, .TX_DMA_REQ_O, .TX_DATA_O,
   .TX_DATA_OE_N_O, .TX_CLK_O, .TX_CLK_OE_N_O, .TX_FS_OE_N_O, .RX_FS_O, .RX_FS_OE_N_O);
